// [core/erb_map.vh]
// Register offsets, field positions and reset values of the receive buffer manager
`ifndef ERB_MAP_VH
`define ERB_MAP_VH
`define ERB_ADDR_W          5
`define ERB_OFF_IE          5'h00
`define ERB_OFF_IF          5'h01
`define ERB_OFF_STAT        5'h02
`define ERB_OFF_CON2        5'h03
`define ERB_OFF_CON1        5'h04
`define ERB_OFF_ST_L        5'h05
`define ERB_OFF_ST_H        5'h06
`define ERB_OFF_ND_L        5'h07
`define ERB_OFF_ND_H        5'h08
`define ERB_OFF_RP_L        5'h09
`define ERB_OFF_RP_H        5'h0a
`define ERB_OFF_FCON        5'h0b
`define ERB_OFF_PKTCNT      5'h0c
`define ERB_OFF_MCON1       5'h0d
`define ERB_OFF_MCON3       5'h0e
`define ERB_OFF_MXFL_L      5'h0f
`define ERB_OFF_MXFL_H      5'h10
`define ERB_OFF_WP_L        5'h11
`define ERB_OFF_WP_H        5'h12
`define ERB_OFF_RD_L        5'h13
`define ERB_OFF_RD_H        5'h14
`define ERB_OFF_RDATA       5'h15
`define ERB_BIT_PKT         6
`define ERB_BIT_RXER        0
`define ERB_BIT_ETH_GLOBAL_IRQ_ENABLE       7
`define ERB_BIT_READ_AUTO_INCREMENT     7
`define ERB_BIT_PACKET_DECREMENT_STROBE      6
`define ERB_BIT_RECEIVE_ENABLE        2
`define ERB_BIT_RXBUSY      2
`define ERB_RST_ST          13'h0000
`define ERB_RST_ND          13'h1fff
`define ERB_RST_RP          13'h0000
`define ERB_RST_FCON        8'ha1
`define ERB_RST_MXFL        16'h0600
`define ERB_CNT_MAX         8'hff
`define ERB_TYPE_LIMIT      16'h05dc
`define ERB_LONG_BITS       50000
`define ERB_HDR_BYTES       13'h0006
`define ERB_SV_LEN_LSB      0
`define ERB_SV_LONG         16
`define ERB_SV_CARRIER      18
`define ERB_SV_CRCERR       20
`define ERB_SV_LENERR       21
`define ERB_SV_RANGE        22
`define ERB_SV_OK           23
`define ERB_SV_MCAST        24
`define ERB_SV_BCAST        25
`define ERB_SV_DRIBBLE      26
`define ERB_SV_CTRL         27
`define ERB_SV_PAUSE        28
`define ERB_SV_UNKOP        29
`define ERB_SV_VLAN         30
`endif

// [core/erb_rx_buffer_manager.v]
// Receive packet buffer manager: circular SRAM writer, pointers, packet count
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "erb_map.vh"
// What this block does
// - Status bits 15-0 hold the frame byte count, stored little-endian.
// - Status bit 23 set only for good CRC and no symbol errors.
// - Status bit 20 set when frame CRC mismatches computed CRC.
// - Status bit 22 set when type/length field exceeds 1500.
// - Status bit 21 set when length field disagrees with payload count.
// - Bit 25 marks broadcast destination, bit 24 multicast destination.
// - Bit 26 marks one to seven dribble bits, which are discarded.
// - Bit 27 marks control frame; bit 28 valid pause frame.
// - Bit 29 marks unknown control opcode; bit 30 VLAN tagged.
// - Bit 18 marks carrier activity seen since previous reception.
// - Bit 16 marks long event or dropped packet since previous reception.
// - Auto-increment read pointer wraps from buffer end to start.
// - Write reaching release pointer aborts packet and sets error flag.
// - Release pointer low byte shadowed until high byte write.
// - Decrement strobe lowers count by one, clearing pending flag at zero unless a packet is accepted in the same cycle.
// - Decrement at zero count leaves count at zero.
// - Count at 255 aborts every new packet and flags error.
// - Write pointer moves after each complete stored packet, and is held at buffer start while receive is disabled except in the cycle after a packet completes.
// - Write pointer never advanced onto release pointer by a stored packet.
// - Six-byte header: next pointer then four-byte status vector.
// - Odd packet end skips a pad byte so packets start even.
// - Accepted packet sets pending flag, moves write pointer, and bumps count unless a decrement strobe in the same cycle lowers it by one.
module erb_rx_buffer_manager #(
   parameter CLK_HZ   = 50000000,
   parameter BIT_HZ   = 10000000,
   parameter LONG_CYC = `ERB_LONG_BITS * (CLK_HZ / BIT_HZ)
) (
   // Clock, reset, enable
   input  wire        sys_clk_i,
   input  wire        reset_i,
   input  wire        clk_en_i,
   // Register port
   input  wire [4:0]  reg_addr_i,
   input  wire [7:0]  reg_wdata_i,
   input  wire        reg_wr_i,
   input  wire        reg_rd_i,
   output reg  [7:0]  reg_rdata_o,
   // Receive stream from MAC/PHY
   input  wire        rx_sof_i,
   input  wire        rx_valid_i,
   input  wire [7:0]  rx_data_i,
   input  wire        rx_eof_i,
   input  wire        rx_crc_err_i,
   input  wire        rx_sym_err_i,
   input  wire        rx_dribble_i,
   input  wire        rx_carrier_evt_i,
   input  wire        rx_drop_evt_i,
   // Packet SRAM write and read
   output reg         mem_we_o,
   output reg  [12:0] mem_waddr_o,
   output reg  [7:0]  mem_wdata_o,
   output wire [12:0] mem_raddr_o,
   input  wire [7:0]  mem_rdata_i,
   // Status
   output wire        irq_o,
   output wire        rx_busy_o
);
   localparam S_IDLE = 4'b0001;
   localparam S_DATA = 4'b0010;
   localparam S_HDR  = 4'b0100;
   localparam S_DROP = 4'b1000;

   reg  [3:0]  state;
   reg  [7:0]  ie;
   reg         pkt_flag;
   reg         err_flag;
   reg         read_auto_increment;
   reg         rx_en;
   reg  [7:0]  con1_other;
   reg  [12:0] rx_start;
   reg  [12:0] rx_end;
   reg  [12:0] rel_ptr;
   reg  [7:0]  rel_shadow;
   reg  [12:0] wr_ptr;
   reg  [12:0] rd_ptr;
   reg  [7:0]  pkt_cnt;
   reg  [7:0]  fcon;
   reg  [7:0]  mcon1;
   reg  [7:0]  mcon3;
   reg  [15:0] max_len;
   reg  [12:0] cur;
   reg  [15:0] byte_cnt;
   reg  [15:0] len_field;
   reg  [7:0]  opc_hi;
   reg  [7:0]  opc_lo;
   reg         bcast;
   reg         mcast;
   reg         pause_da;
   reg  [2:0]  hdr_idx;
   reg  [31:0] sv;
   reg  [12:0] next_pkt;
   reg         carrier_seen;
   reg         drop_seen;
   reg  [31:0] long_cnt;
   reg         long_evt;
   wire        rd_hit = reg_rd_i && reg_addr_i == `ERB_OFF_RDATA;

   // Circular increment within the receive ring
   function [12:0] ring_inc;
      input [12:0] p;
      input [12:0] st;
      input [12:0] nd;
      begin
         ring_inc = (p == nd) ? st : p + 13'h0001;
      end
   endfunction

   function [12:0] ring_add;
      input [12:0] p;
      input [12:0] n;
      input [12:0] st;
      input [12:0] nd;
      reg   [13:0] s;
      begin
         s = {1'b0, p} + {1'b0, n};
         if (s > {1'b0, nd})
            ring_add = s[12:0] - (nd - st + 13'h0001);
         else
            ring_add = s[12:0];
      end
   endfunction

   wire        wr_acc   = reg_wr_i & clk_en_i;
   wire        dec_req  = wr_acc && reg_addr_i == `ERB_OFF_CON2 && reg_wdata_i[`ERB_BIT_PACKET_DECREMENT_STROBE];
   wire [12:0] cur_next = ring_inc(cur, rx_start, rx_end);
   wire        is_ctrl  = (len_field == 16'h8808);
   wire        is_vlan  = (len_field == 16'h8100);
   wire        is_range = (len_field > `ERB_TYPE_LIMIT);
   wire        len_bad  = !is_range && (byte_cnt >= 16'd18) &&
                          (len_field != byte_cnt - 16'd18) &&
                          !(len_field < 16'd46 && byte_cnt == 16'd64);
   wire        crc_ok   = !rx_crc_err_i;
   wire        pkt_good = crc_ok && !rx_sym_err_i;
   wire        last_odd = cur[0];
   wire [12:0] end_ptr  = last_odd ? cur_next : cur;

   assign mem_raddr_o = rd_ptr;
   assign rx_busy_o   = (state != S_IDLE);
   assign irq_o       = ie[`ERB_BIT_ETH_GLOBAL_IRQ_ENABLE] &
                        ((ie[`ERB_BIT_PKT] & pkt_flag) | (ie[`ERB_BIT_RXER] & err_flag));

   // Receive engine and counters
   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         state        <= S_IDLE;
         cur          <= 13'h0000;
         wr_ptr       <= `ERB_RST_ST;
         pkt_cnt      <= 8'h00;
         pkt_flag     <= 1'b0;
         err_flag     <= 1'b0;
         byte_cnt     <= 16'h0000;
         len_field    <= 16'h0000;
         opc_hi       <= 8'h00;
         opc_lo       <= 8'h00;
         bcast        <= 1'b0;
         mcast        <= 1'b0;
         pause_da     <= 1'b0;
         hdr_idx      <= 3'h0;
         sv           <= 32'h0000_0000;
         next_pkt     <= 13'h0000;
         carrier_seen <= 1'b0;
         drop_seen    <= 1'b0;
         long_cnt     <= 32'h0000_0000;
         long_evt     <= 1'b0;
         mem_we_o     <= 1'b0;
         mem_waddr_o  <= 13'h0000;
         mem_wdata_o  <= 8'h00;
      end else if (clk_en_i) begin
         mem_we_o <= 1'b0;
         if (rx_carrier_evt_i)
            carrier_seen <= 1'b1;
         if (rx_drop_evt_i)
            drop_seen <= 1'b1;
         if (dec_req && pkt_cnt != 8'h00) begin
            pkt_cnt <= pkt_cnt - 8'h01;
            if (pkt_cnt == 8'h01)
               pkt_flag <= 1'b0;
         end
         if (wr_acc && reg_addr_i == `ERB_OFF_IF) begin
            if (!reg_wdata_i[`ERB_BIT_PKT])
               pkt_flag <= 1'b0;
            if (!reg_wdata_i[`ERB_BIT_RXER])
               err_flag <= 1'b0;
         end
         if (!rx_en)
            wr_ptr <= rx_start;
         case (state)
            S_IDLE: begin
               if (rx_sof_i && rx_en) begin
                  if (pkt_cnt == `ERB_CNT_MAX) begin
                     err_flag  <= 1'b1;
                     drop_seen <= 1'b1;
                     state     <= S_DROP;
                  end else begin
                     cur      <= ring_add(wr_ptr, `ERB_HDR_BYTES, rx_start, rx_end);
                     byte_cnt <= 16'h0000;
                     len_field <= 16'h0000;
                     long_cnt <= 32'h0000_0000;
                     long_evt <= 1'b0;
                     bcast    <= 1'b1;
                     mcast    <= 1'b0;
                     pause_da <= 1'b1;
                     state    <= S_DATA;
                  end
               end
            end
            S_DATA: begin
               if (long_cnt == LONG_CYC - 1)
                  long_evt <= 1'b1;
               long_cnt <= long_cnt + 32'h0000_0001;
               if (rx_valid_i) begin
                  // Never write onto the release pointer
                  if (cur == rel_ptr) begin
                     err_flag  <= 1'b1;
                     drop_seen <= 1'b1;
                     state     <= S_DROP;
                  end else begin
                     mem_we_o    <= 1'b1;
                     mem_waddr_o <= cur;
                     mem_wdata_o <= rx_data_i;
                     cur         <= cur_next;
                     byte_cnt    <= byte_cnt + 16'h0001;
                     if (byte_cnt < 16'd6 && rx_data_i != 8'hff)
                        bcast <= 1'b0;
                     if (byte_cnt == 16'd0)
                        mcast <= rx_data_i[0];
                     if (byte_cnt < 16'd6 && rx_data_i != (({8'h01, 8'h80, 8'hc2, 8'h00,
                         8'h00, 8'h01} >> (8 * (5 - byte_cnt[2:0]))) & 48'h0000_0000_00ff))
                        pause_da <= 1'b0;
                     if (byte_cnt == 16'd12)
                        len_field[15:8] <= rx_data_i;
                     if (byte_cnt == 16'd13)
                        len_field[7:0] <= rx_data_i;
                     if (byte_cnt == 16'd14)
                        opc_hi <= rx_data_i;
                     if (byte_cnt == 16'd15)
                        opc_lo <= rx_data_i;
                  end
               end else if (rx_eof_i) begin
                  // Pad to even start; keep one byte free
                  if (end_ptr == rel_ptr) begin
                     err_flag  <= 1'b1;
                     drop_seen <= 1'b1;
                     state     <= S_IDLE;
                  end else begin
                     next_pkt <= end_ptr;
                     // Status vector assembly, reserved bits zero
                     sv <= {1'b0,
                            is_vlan,
                            is_ctrl && {opc_hi, opc_lo} != 16'h0001,
                            is_ctrl && {opc_hi, opc_lo} == 16'h0001 && pause_da,
                            is_ctrl,
                            rx_dribble_i,
                            bcast && mcast,
                            mcast && !bcast,
                            pkt_good,
                            is_range,
                            len_bad,
                            !crc_ok,
                            1'b0,
                            carrier_seen,
                            1'b0,
                            long_evt | drop_seen,
                            byte_cnt};
                     hdr_idx <= 3'h0;
                     cur     <= wr_ptr;
                     state   <= S_HDR;
                  end
               end
            end
            S_HDR: begin
               // Next pointer then status vector, little-endian
               mem_we_o    <= 1'b1;
               mem_waddr_o <= cur;
               cur         <= cur_next;
               hdr_idx     <= hdr_idx + 3'h1;
               case (hdr_idx)
                  3'h0:    mem_wdata_o <= next_pkt[7:0];
                  3'h1:    mem_wdata_o <= {3'h0, next_pkt[12:8]};
                  3'h2:    mem_wdata_o <= sv[7:0];
                  3'h3:    mem_wdata_o <= sv[15:8];
                  3'h4:    mem_wdata_o <= sv[23:16];
                  default: mem_wdata_o <= sv[31:24];
               endcase
               if (hdr_idx == 3'h5) begin
                  wr_ptr       <= next_pkt;
                  if (!(dec_req && pkt_cnt != 8'h00))
                     pkt_cnt <= pkt_cnt + 8'h01;
                  pkt_flag     <= 1'b1;
                  carrier_seen <= rx_carrier_evt_i;
                  drop_seen    <= rx_drop_evt_i;
                  state        <= S_IDLE;
               end
            end
            S_DROP: begin
               if (rx_eof_i)
                  state <= S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // Software registers and read pointer
   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         ie         <= 8'h00;
         read_auto_increment    <= 1'b1;
         rx_en      <= 1'b0;
         con1_other <= 8'h00;
         rx_start   <= `ERB_RST_ST;
         rx_end     <= `ERB_RST_ND;
         rel_ptr    <= `ERB_RST_RP;
         rel_shadow <= 8'h00;
         rd_ptr     <= 13'h0000;
         fcon       <= `ERB_RST_FCON;
         mcon1      <= 8'h00;
         mcon3      <= 8'h00;
         max_len    <= `ERB_RST_MXFL;
      end else if (clk_en_i) begin
         // Sequential read wraps at ring end
         if (rd_hit && read_auto_increment)
            rd_ptr <= ring_inc(rd_ptr, rx_start, rx_end);
         if (reg_wr_i) begin
            case (reg_addr_i)
               `ERB_OFF_IE:     ie <= reg_wdata_i;
               `ERB_OFF_CON2:   read_auto_increment <= reg_wdata_i[`ERB_BIT_READ_AUTO_INCREMENT];
               `ERB_OFF_CON1: begin
                  rx_en      <= reg_wdata_i[`ERB_BIT_RECEIVE_ENABLE];
                  con1_other <= reg_wdata_i & 8'hfb;
               end
               `ERB_OFF_ST_L:   rx_start[7:0] <= reg_wdata_i;
               `ERB_OFF_ST_H:   rx_start[12:8] <= reg_wdata_i[4:0];
               `ERB_OFF_ND_L:   rx_end[7:0] <= reg_wdata_i;
               `ERB_OFF_ND_H:   rx_end[12:8] <= reg_wdata_i[4:0];
               // Low byte held until high byte write
               `ERB_OFF_RP_L:   rel_shadow <= reg_wdata_i;
               `ERB_OFF_RP_H:   rel_ptr <= {reg_wdata_i[4:0], rel_shadow};
               `ERB_OFF_FCON:   fcon <= reg_wdata_i;
               `ERB_OFF_MCON1:  mcon1 <= reg_wdata_i;
               `ERB_OFF_MCON3:  mcon3 <= reg_wdata_i;
               `ERB_OFF_MXFL_L: max_len[7:0] <= reg_wdata_i;
               `ERB_OFF_MXFL_H: max_len[15:8] <= reg_wdata_i;
               `ERB_OFF_RD_L:   rd_ptr[7:0] <= reg_wdata_i;
               `ERB_OFF_RD_H:   rd_ptr[12:8] <= reg_wdata_i[4:0];
               default: ;
            endcase
         end
      end
   end

   // Read data, one cycle after the strobe; decrement bit reads zero
   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         reg_rdata_o <= 8'h00;
      end else if (clk_en_i) begin
         reg_rdata_o <= 8'h00;
         if (reg_rd_i) begin
            case (reg_addr_i)
               `ERB_OFF_IE:     reg_rdata_o <= ie;
               `ERB_OFF_IF:     reg_rdata_o <= {1'b0, pkt_flag, 5'h00, err_flag};
               `ERB_OFF_STAT:   reg_rdata_o <= {5'h00, rx_busy_o, 2'h0};
               `ERB_OFF_CON2:   reg_rdata_o <= {read_auto_increment, 7'h00};
               `ERB_OFF_CON1:   reg_rdata_o <= con1_other | {5'h00, rx_en, 2'h0};
               `ERB_OFF_ST_L:   reg_rdata_o <= rx_start[7:0];
               `ERB_OFF_ST_H:   reg_rdata_o <= {3'h0, rx_start[12:8]};
               `ERB_OFF_ND_L:   reg_rdata_o <= rx_end[7:0];
               `ERB_OFF_ND_H:   reg_rdata_o <= {3'h0, rx_end[12:8]};
               `ERB_OFF_RP_L:   reg_rdata_o <= rel_ptr[7:0];
               `ERB_OFF_RP_H:   reg_rdata_o <= {3'h0, rel_ptr[12:8]};
               `ERB_OFF_FCON:   reg_rdata_o <= fcon;
               `ERB_OFF_PKTCNT: reg_rdata_o <= pkt_cnt;
               `ERB_OFF_MCON1:  reg_rdata_o <= mcon1;
               `ERB_OFF_MCON3:  reg_rdata_o <= mcon3;
               `ERB_OFF_MXFL_L: reg_rdata_o <= max_len[7:0];
               `ERB_OFF_MXFL_H: reg_rdata_o <= max_len[15:8];
               `ERB_OFF_WP_L:   reg_rdata_o <= wr_ptr[7:0];
               `ERB_OFF_WP_H:   reg_rdata_o <= {3'h0, wr_ptr[12:8]};
               `ERB_OFF_RD_L:   reg_rdata_o <= rd_ptr[7:0];
               `ERB_OFF_RD_H:   reg_rdata_o <= {3'h0, rd_ptr[12:8]};
               `ERB_OFF_RDATA:  reg_rdata_o <= mem_rdata_i;
               default:         reg_rdata_o <= 8'h00;
            endcase
         end
      end
   end
endmodule

// [sim/erb_rx_buffer_manager_props.sv]
// Port-level checks of the receive buffer manager
`timescale 1ns/1ps
`include "erb_map.vh"
module erb_props (
   // Clock and reset
   input wire        sys_clk_i,
   input wire        reset_i,
   // Register port
   input wire [4:0]  reg_addr_i,
   input wire [7:0]  reg_wdata_i,
   input wire        reg_wr_i,
   input wire        reg_rd_i,
   input wire [7:0]  reg_rdata_o,
   // Stream and SRAM
   input wire        rx_sof_i,
   input wire        rx_eof_i,
   input wire        mem_we_o,
   input wire [12:0] mem_waddr_o,
   input wire [12:0] mem_raddr_o,
   // Status
   input wire        irq_o,
   input wire        rx_busy_o
);
   default clocking dc @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
      else $error("read data not idle");
   a_strobe_clear: assert property (reg_rd_i && reg_addr_i == `ERB_OFF_CON2
      |=> !reg_rdata_o[`ERB_BIT_PACKET_DECREMENT_STROBE]) else $error("decrement bit readable");
   a_idle_nowrite: assert property (!rx_busy_o && !$past(rx_busy_o) |-> !mem_we_o)
      else $error("sram write while idle");
   a_waddr_step: assert property (mem_we_o && $past(mem_we_o)
      |-> mem_waddr_o == $past(mem_waddr_o) + 13'h0001 || mem_waddr_o < $past(mem_waddr_o))
      else $error("sram address skipped");
   a_irq_gate: assert property (reg_wr_i && reg_addr_i == `ERB_OFF_IE
      && !reg_wdata_i[`ERB_BIT_ETH_GLOBAL_IRQ_ENABLE] |=> !irq_o) else $error("irq despite global off");
   a_rptr_hold: assert property (!reg_wr_i && !reg_rd_i |=> $stable(mem_raddr_o))
      else $error("read pointer moved alone");
   a_rptr_step: assert property (reg_rd_i && reg_addr_i == `ERB_OFF_RDATA
      |=> mem_raddr_o == $past(mem_raddr_o) + 13'h0001 || mem_raddr_o <= $past(mem_raddr_o))
      else $error("read pointer bad step");
   a_busy_rise: assert property ($rose(rx_busy_o) |-> $past(rx_sof_i))
      else $error("engine started without frame");
   c_header: cover property (rx_eof_i ##2 mem_we_o [*6]);
   c_irq: cover property ($rose(irq_o));
   c_data_read: cover property (reg_rd_i && reg_addr_i == `ERB_OFF_RDATA);
endmodule
bind erb_rx_buffer_manager erb_props chk_u (.sys_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i,
   .reg_wr_i, .reg_rd_i, .reg_rdata_o, .rx_sof_i, .rx_eof_i, .mem_we_o, .mem_waddr_o,
   .mem_raddr_o, .irq_o, .rx_busy_o);

// [sim/erb_net_model.sv]
// Network receive path driver and packet SRAM model
`timescale 1ns/1ps
module erb_net_model (
   // Clock
   input  wire        sys_clk_i,
   // Receive stream toward the block
   output reg         rx_sof_o,
   output reg         rx_valid_o,
   output reg  [7:0]  rx_data_o,
   output reg         rx_eof_o,
   output reg         rx_crc_err_o,
   output reg         rx_sym_err_o,
   output reg         rx_dribble_o,
   output reg         rx_carrier_evt_o,
   output reg         rx_drop_evt_o,
   // Packet SRAM
   input  wire        mem_we_i,
   input  wire [12:0] mem_waddr_i,
   input  wire [7:0]  mem_wdata_i,
   input  wire [12:0] mem_raddr_i,
   output wire [7:0]  mem_rdata_o
);
   reg     [7:0] mem [0:8191];
   integer       k;
   initial begin
      {rx_sof_o, rx_valid_o, rx_eof_o, rx_crc_err_o, rx_sym_err_o} = 5'h00;
      {rx_dribble_o, rx_carrier_evt_o, rx_drop_evt_o, rx_data_o} = 11'h000;
      for (k = 0; k < 8192; k = k + 1) begin
         mem[k] = 8'h00;
      end
   end
   always @(posedge sys_clk_i) begin
      if (mem_we_i) begin
         mem[mem_waddr_i] <= mem_wdata_i;
      end
   end
   assign mem_rdata_o = mem[mem_raddr_i];
   // Frame: destination bytes, type 0800, zero fill
   task send(input integer n, input [7:0] dst, input crc, input drb);
      integer i;
      begin
         @(posedge sys_clk_i) rx_sof_o <= 1'b1;
         for (i = 0; i < n; i = i + 1) begin
            @(posedge sys_clk_i) rx_sof_o <= 1'b0;
            rx_valid_o <= 1'b1;
            rx_data_o <= (i < 6) ? dst : ((i == 12) ? 8'h08 : 8'h00);
         end
         @(posedge sys_clk_i) rx_valid_o <= 1'b0;
         rx_data_o <= ~rx_data_o;
         rx_eof_o <= 1'b1;
         rx_crc_err_o <= crc;
         rx_dribble_o <= drb;
         @(posedge sys_clk_i) rx_eof_o <= 1'b0;
         rx_crc_err_o <= 1'b0;
         rx_dribble_o <= 1'b0;
      end
   endtask
   // Idle line activity and a dropped frame
   task evt;
      begin
         @(posedge sys_clk_i) rx_carrier_evt_o <= 1'b1;
         rx_drop_evt_o <= 1'b1;
         @(posedge sys_clk_i) rx_carrier_evt_o <= 1'b0;
         rx_drop_evt_o <= 1'b0;
      end
   endtask
endmodule

// [sim/erb_rx_buffer_manager_bench.sv]
// Self-checking bench of the receive buffer manager
`timescale 1ns/1ps
`include "erb_map.vh"
module erb_rx_buffer_manager_bench;
   reg         sys_clk_i, reset_i, clk_en_i, reg_wr_i, reg_rd_i;
   reg  [4:0]  reg_addr_i;
   reg  [7:0]  reg_wdata_i;
   wire [7:0]  reg_rdata_o, rx_data_i, mem_wdata_o, mem_rdata_i;
   wire        rx_sof_i, rx_valid_i, rx_eof_i, rx_crc_err_i, rx_sym_err_i, rx_dribble_i;
   wire        rx_carrier_evt_i, rx_drop_evt_i, mem_we_o, irq_o, rx_busy_o;
   wire [12:0] mem_waddr_o, mem_raddr_o;
   integer     n_mismatch, compares, i;
   erb_rx_buffer_manager #(.LONG_CYC(100)) dut_u (.sys_clk_i, .reset_i, .clk_en_i,
      .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .rx_sof_i, .rx_valid_i,
      .rx_data_i, .rx_eof_i, .rx_crc_err_i, .rx_sym_err_i, .rx_dribble_i, .rx_carrier_evt_i,
      .rx_drop_evt_i, .mem_we_o, .mem_waddr_o, .mem_wdata_o, .mem_raddr_o, .mem_rdata_i,
      .irq_o, .rx_busy_o);
   erb_net_model net_u (.sys_clk_i(sys_clk_i), .rx_sof_o(rx_sof_i), .rx_valid_o(rx_valid_i),
      .rx_data_o(rx_data_i), .rx_eof_o(rx_eof_i), .rx_crc_err_o(rx_crc_err_i),
      .rx_sym_err_o(rx_sym_err_i), .rx_dribble_o(rx_dribble_i),
      .rx_carrier_evt_o(rx_carrier_evt_i), .rx_drop_evt_o(rx_drop_evt_i),
      .mem_we_i(mem_we_o), .mem_waddr_i(mem_waddr_o), .mem_wdata_i(mem_wdata_o),
      .mem_raddr_i(mem_raddr_o), .mem_rdata_o(mem_rdata_i));
   initial begin
      sys_clk_i = 1'b0;
      forever #10 sys_clk_i = ~sys_clk_i;
   end
   task complete_run;
      begin
         $display("compares %0d n_mismatch %0d", compares, n_mismatch);
         if (n_mismatch == 0 && compares > 0) $display("All checks passed");
         else $display("Checks failed");
         $finish;
      end
   endtask
   task chk(input [12:0] seen, input [12:0] exp, input [8*8:1] nm);
      begin
         compares = compares + 1;
         if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task wr(input [4:0] a, input [7:0] d);
      begin
         @(posedge sys_clk_i) reg_wr_i <= 1'b1;
         reg_addr_i <= a;
         reg_wdata_i <= d;
         @(posedge sys_clk_i) reg_wr_i <= 1'b0;
      end
   endtask
   task rd(input [4:0] a, input [7:0] e);
      begin
         @(posedge sys_clk_i) reg_rd_i <= 1'b1;
         reg_addr_i <= a;
         @(posedge sys_clk_i) reg_rd_i <= 1'b0;
         #1 chk({5'h00, reg_rdata_o}, {5'h00, e}, "register");
      end
   endtask
   task hdr(input [12:0] b, input [47:0] e);
      integer j;
      begin
         for (j = 0; j < 6; j = j + 1) chk({5'h00, net_u.mem[b + j]}, {5'h00, e[8*j +: 8]}, "header");
      end
   endtask
   task wait_idle;
      integer k;
      begin
         k = 0;
         while (rx_busy_o !== 1'b0 && k < 400) begin
            @(posedge sys_clk_i) k = k + 1;
            #1;
         end
         // Let the last header byte reach the memory model
         @(posedge sys_clk_i) #1;
         if (k == 400) begin
            n_mismatch = n_mismatch + 1;
            complete_run;
         end
      end
   endtask
   initial begin
      n_mismatch = 0;
      compares = 0;
      {reset_i, clk_en_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = {2'b11, 15'h0000};
      repeat (16) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      rd(`ERB_OFF_ND_L, 8'hff);
      rd(`ERB_OFF_ND_H, 8'h1f);
      rd(`ERB_OFF_FCON, 8'ha1);
      rd(`ERB_OFF_MXFL_H, 8'h06);
      rd(5'h1f, 8'h00);
      rd(`ERB_OFF_CON2, 8'h80);
      wr(`ERB_OFF_IE, 8'hc1);
      wr(`ERB_OFF_FCON, 8'h00);
      wr(`ERB_OFF_ND_L, 8'h3f);
      wr(`ERB_OFF_ND_H, 8'h00);
      wr(`ERB_OFF_RP_L, 8'h3e);
      rd(`ERB_OFF_RP_L, 8'h00);
      wr(`ERB_OFF_RP_H, 8'h00);
      rd(`ERB_OFF_RP_L, 8'h3e);
      wr(`ERB_OFF_CON1, 8'h04);
      net_u.send(15, 8'hff, 1'b0, 1'b0);
      wait_idle;
      hdr(13'h0000, 48'h02c0000f0016);
      rd(`ERB_OFF_WP_L, 8'h16);
      rd(`ERB_OFF_IF, 8'h40);
      chk({12'h000, irq_o}, 13'h0001, "irq");
      net_u.evt;
      net_u.send(15, 8'h01, 1'b1, 1'b1);
      wait_idle;
      hdr(13'h0016, 48'h0555000f002c);
      rd(`ERB_OFF_PKTCNT, 8'h02);
      wr(`ERB_OFF_CON2, 8'hc0);
      rd(`ERB_OFF_PKTCNT, 8'h01);
      rd(`ERB_OFF_IF, 8'h40);
      wr(`ERB_OFF_CON2, 8'hc0);
      rd(`ERB_OFF_IF, 8'h00);
      chk({12'h000, irq_o}, 13'h0000, "irq");
      wr(`ERB_OFF_CON2, 8'hc0);
      rd(`ERB_OFF_PKTCNT, 8'h00);
      wr(`ERB_OFF_RD_L, 8'h3f);
      wr(`ERB_OFF_RD_H, 8'h00);
      rd(`ERB_OFF_RDATA, 8'h00);
      rd(`ERB_OFF_RD_L, 8'h00);
      rd(`ERB_OFF_RDATA, 8'h16);
      wr(`ERB_OFF_RP_L, 8'h34);
      wr(`ERB_OFF_RP_H, 8'h00);
      net_u.send(15, 8'hff, 1'b0, 1'b0);
      wait_idle;
      rd(`ERB_OFF_IF, 8'h01);
      rd(`ERB_OFF_WP_L, 8'h2c);
      chk({5'h00, net_u.mem[13'h0034]}, 13'h0000, "sram");
      wr(`ERB_OFF_IF, 8'h00);
      wr(`ERB_OFF_CON1, 8'h00);
      wr(`ERB_OFF_ND_L, 8'hff);
      wr(`ERB_OFF_ND_H, 8'h1f);
      wr(`ERB_OFF_RP_L, 8'h00);
      wr(`ERB_OFF_RP_H, 8'h1f);
      wr(`ERB_OFF_CON1, 8'h04);
      for (i = 0; i < 255; i = i + 1) begin
         net_u.send(1, 8'h00, 1'b0, 1'b0);
         wait_idle;
      end
      hdr(13'h0000, 48'h008100010008);
      rd(`ERB_OFF_PKTCNT, 8'hff);
      net_u.send(1, 8'h00, 1'b0, 1'b0);
      wait_idle;
      rd(`ERB_OFF_PKTCNT, 8'hff);
      rd(`ERB_OFF_WP_L, 8'hf8);
      rd(`ERB_OFF_WP_H, 8'h07);
      rd(`ERB_OFF_PKTCNT, 8'hff);
      rd(`ERB_OFF_IF, 8'h41);
      wr(`ERB_OFF_IE, 8'h41);
      #1 chk({12'h000, irq_o}, 13'h0000, "irq");
      complete_run;
   end
endmodule
